/* File: tp_pkg.sv */
// Package of register offsets, field positions and constants for the timer pair.
`default_nettype none
package tp_pkg;
  // ----------------------------------------
  // Register offsets (word addresses).
  // ----------------------------------------
  localparam logic [3:0] TP_ADDR_LOW_CTRL = 4'h0;
  localparam logic [3:0] TP_ADDR_HIGH_CTRL = 4'h1;
  localparam logic [3:0] TP_ADDR_PERIOD_LOW = 4'h2;
  localparam logic [3:0] TP_ADDR_PERIOD_HIGH = 4'h3;
  localparam logic [3:0] TP_ADDR_COUNT_LOW = 4'h4;
  localparam logic [3:0] TP_ADDR_COUNT_HIGH = 4'h5;
  localparam logic [3:0] TP_ADDR_IRQ_STATUS = 4'h6;
  localparam logic [3:0] TP_ADDR_IRQ_MASK = 4'h7;
  localparam logic [3:0] TP_ADDR_IRQ_PRIO = 4'h8;
  // ----------------------------------------
  // Control register field positions.
  // ----------------------------------------
  localparam int TP_BIT_RUN = 15;
  localparam int TP_BIT_IDLE = 13;
  localparam int TP_BIT_GATE = 6;
  localparam int TP_BIT_PS_HI = 5;
  localparam int TP_BIT_PS_LO = 4;
  localparam int TP_BIT_CONCAT = 3;
  localparam int TP_BIT_CSRC = 1;
  // Writable bits of each control register; all others read as zero.
  localparam logic [15:0] TP_LOW_CTRL_MASK = 16'hA07A;
  localparam logic [15:0] TP_HIGH_CTRL_MASK = 16'hA072;
  // Values after reset.
  localparam logic [15:0] TP_CTRL_RST = 16'h0000;
  localparam logic [15:0] TP_PERIOD_RST = 16'hFFFF;
  // Prescale divide counts minus one for settings 00, 01, 10, 11.
  localparam logic [7:0] TP_DIV1_M1 = 8'h00;
  localparam logic [7:0] TP_DIV8_M1 = 8'h07;
  localparam logic [7:0] TP_DIV64_M1 = 8'h3F;
  localparam logic [7:0] TP_DIV256_M1 = 8'hFF;
  // Interrupt status bit positions.
  localparam int TP_IRQ_LOW = 0;
  localparam int TP_IRQ_HIGH = 1;
endpackage
`default_nettype wire

/* File: tp_prescale.sv */
// One timer input stage: source select, gating, prescaler and clock synchroniser.
`default_nettype none
module tp_prescale #(
  parameter bit SYNC_BEFORE = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic csrc,
  input wire logic gate_en,
  input wire logic gate_pin,
  input wire logic [1:0] ps_sel,
  input wire logic ext_pin,
  output logic tick
);
  import tp_pkg::*;

  // ----------------------------------------
  // Helpers.
  // ----------------------------------------
  // Maps the prescale field to its terminal count.
  function automatic logic [7:0] div_m1(input logic [1:0] sel);
    unique case (sel)
      2'b00: div_m1 = TP_DIV1_M1;
      2'b01: div_m1 = TP_DIV8_M1;
      2'b10: div_m1 = TP_DIV64_M1;
      2'b11: div_m1 = TP_DIV256_M1;
    endcase
  endfunction

  logic s1_r, s2_r, s3_r; // Synchroniser pair and edge history.
  logic [7:0] pc_r, pc_nxt; // Prescale counter.
  logic ptick_r, ptick_nxt; // Registered output of the prescaler.
  logic raw_in; // Rising edge of the unsynchronised pin, the prescaler input.
  logic ext_edge; // Rising edge of the synchronised pin.
  logic src_pulse; // One event into the prescaler.
  logic pext_r, pext_nxt; // Prescaled external level for sync-after style.

  // ----------------------------------------
  // Input selection.
  // ----------------------------------------
  // The low timer prescales the raw pin, then synchronises; the high timer synchronises first.
  assign ext_edge = s2_r & ~s3_r;
  always_comb begin
    if (csrc) begin
      // Gate is ignored with the external source selected.
      src_pulse = SYNC_BEFORE ? ext_edge : 1'b0;
    end else begin
      // Gated mode counts instruction clocks only while the gate is high.
      src_pulse = gate_en ? gate_pin : 1'b1;
    end
  end

  // ----------------------------------------
  // Prescaler.
  // ----------------------------------------
  // Divides the selected events by 1, 8, 64 or 256; cleared while stopped.
  always_comb begin
    pc_nxt = pc_r;
    ptick_nxt = 1'b0;
    pext_nxt = pext_r;
    if (!run) begin
      pc_nxt = 8'h00;
      pext_nxt = 1'b0;
    end else if (csrc && !SYNC_BEFORE) begin
      // Pin edges are sampled as synchronous, then divided, then resynchronised.
      pc_nxt = pc_r + 8'h01;
      if (pc_r >= div_m1(ps_sel)) begin
        pc_nxt = 8'h00;
      end
      pext_nxt = (pc_r >= div_m1(ps_sel)) ? ~pext_r : pext_r;
    end else if (src_pulse) begin
      if (pc_r >= div_m1(ps_sel)) begin
        pc_nxt = 8'h00;
        ptick_nxt = 1'b1;
      end else begin
        pc_nxt = pc_r + 8'h01;
      end
    end
  end

  // Counting only on raw pin rising edges keeps the sync-after path honest.
  logic pin_d_r;
  assign raw_in = ext_pin & ~pin_d_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= 8'h00;
      ptick_r <= 1'b0;
      pext_r <= 1'b0;
      pin_d_r <= 1'b0;
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      pin_d_r <= ext_pin;
      ptick_r <= ptick_nxt;
      // The divider advances on raw pin edges only in the sync-after style.
      if (csrc && !SYNC_BEFORE && run) begin
        if (raw_in) begin
          pc_r <= pc_nxt;
          pext_r <= pext_nxt;
        end
      end else begin
        pc_r <= pc_nxt;
        pext_r <= pext_nxt;
      end
      // The synchroniser looks at the pin or the prescaled level.
      s1_r <= SYNC_BEFORE ? ext_pin : pext_r;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A toggle of the prescaled level is one tick after synchronisation.
  assign tick = run & ((csrc && !SYNC_BEFORE) ? (s2_r ^ s3_r) : ptick_r);
endmodule
`default_nettype wire

/* File: tp_timer_pair.sv */
// Top of the 16/32-bit timer pair with its register port and interrupt logic.
//
// How it works
// - Clock source bit picks pin or instruction clock.
// - Gate bit enables gated counting, internal only.
// - Prescale field divides by 1, 8, 64, 256.
// - Run bit starts timer; low run drives pair.
// - Idle halt bit stops timer during Idle.
// - Concat bit joins both counters into 32 bits.
// - High counter is upper word, low is lower.
// - Pair uses low control, except high idle bit.
// - Pair interrupts through high timer's controls only.
// - Pair period is high word over low word.
// - Pair runs in Idle if high idle clear.
// - Unimplemented bits read zero; controls reset cleared.
// - Low timer synchronises pin after its prescaler.
// - High timer synchronises pin before its prescaler.
//
// The plain strobed port and the register addresses were decided locally.
`default_nettype none
module tp_timer_pair (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  input wire logic idle_mode,
  input wire logic ext_clock_pin_low,
  input wire logic ext_clock_pin_high,
  input wire logic gate_pin_low,
  input wire logic gate_pin_high,
  output logic irq,
  output logic [2:0] irq_priority_out
);
  import tp_pkg::*;
  // Word addresses on the four-bit port:
  // 0 low control, 1 high control.
  // 2 low period, 3 high period.
  // 4 low counter, 5 high counter.
  // 6 sticky event status, low in bit 0.
  // 7 interrupt mask, same layout.
  // 8 priorities, high in bits 5 to 3.
  // Other addresses ignore writes.
  // They also read as zero.
  // No access ever waits, so strobes
  // may come on every cycle.

  // ----------------------------------------
  // Register state.
  // ----------------------------------------
  logic [15:0] timer_low_control_r, timer_low_control_nxt; // Low timer control.
  logic [15:0] timer_high_control_r, timer_high_control_nxt; // High timer control.
  logic [15:0] period_low_word_r, period_low_word_nxt; // Low period word.
  logic [15:0] period_high_word_r, period_high_word_nxt; // High period word.
  logic [15:0] count_low_r, count_low_nxt; // Low counter.
  logic [15:0] count_high_r, count_high_nxt; // High counter.
  logic [1:0] irq_stat_r, irq_stat_nxt; // Sticky event flags.
  logic [1:0] irq_enable_r, irq_enable_nxt; // Interrupt mask.
  logic [5:0] irq_prio_r, irq_prio_nxt; // Two 3-bit priorities.
  logic [15:0] rdata_r, rdata_nxt; // Read data, one cycle after the strobe.

  // Decoded controls.
  logic concat; // Pair joined into 32 bits.
  logic run_low, run_high; // Effective run enables after idle gating.
  logic tick_low, tick_high; // Prescaled ticks.
  logic [15:0] ctl_b, ctl_c; // Control applied to each stage.
  logic ev_low, ev_high; // Period-match events.
  logic [31:0] pair_count, pair_period;

  // In 32-bit mode the low control register steers the pair, except for the high idle bit.
  assign concat = timer_low_control_r[TP_BIT_CONCAT];
  assign ctl_b = timer_low_control_r;
  assign ctl_c = timer_high_control_r;

  // Each timer runs while its run bit
  // is set and Idle does not halt it.
  // In pair mode the high stage is
  // parked; the low stage ticks both.
  // The high idle bit still counts.
  // Split the pair only when stopped:
  // the high counter would otherwise
  // jump back to its own stage at once.
  // Idle halting: the pair follows the high idle bit alone.
  always_comb begin
    if (concat) begin
      run_low = ctl_b[TP_BIT_RUN] & ~(idle_mode & ctl_c[TP_BIT_IDLE]);
      run_high = 1'b0;
    end else begin
      run_low = ctl_b[TP_BIT_RUN] & ~(idle_mode & ctl_b[TP_BIT_IDLE]);
      run_high = ctl_c[TP_BIT_RUN] & ~(idle_mode & ctl_c[TP_BIT_IDLE]);
    end
  end

  // ----------------------------------------
  // Input stages.
  // ----------------------------------------
  // Low stage: sync after prescaler. Pair mode takes its pin and settings.
  tp_prescale #(.SYNC_BEFORE(1'b0)) u_pre_low (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(run_low),
    .csrc(ctl_b[TP_BIT_CSRC]),
    .gate_en(ctl_b[TP_BIT_GATE]),
    .gate_pin(gate_pin_low),
    .ps_sel(ctl_b[TP_BIT_PS_HI:TP_BIT_PS_LO]),
    .ext_pin(ext_clock_pin_low),
    .tick(tick_low)
  );

  // High stage: sync before prescaler.
  tp_prescale #(.SYNC_BEFORE(1'b1)) u_pre_high (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(run_high),
    .csrc(ctl_c[TP_BIT_CSRC]),
    .gate_en(ctl_c[TP_BIT_GATE]),
    .gate_pin(gate_pin_high),
    .ps_sel(ctl_c[TP_BIT_PS_HI:TP_BIT_PS_LO]),
    .ext_pin(ext_clock_pin_high),
    .tick(tick_high)
  );

  // ----------------------------------------
  // Counters.
  // ----------------------------------------
  // One process owns both counters, so
  // pair and split modes never fight.
  // Pair mode uses one 32-bit compare
  // and increment; the wider adder is
  // the price of a same-cycle carry.
  // Software reads the halves apart,
  // so a carry may fall between reads.
  // A zero period flags every tick.
  // Counting is upward only.
  // High word over low word for both count and period.
  assign pair_count = {count_high_r, count_low_r};
  assign pair_period = {period_high_word_r, period_low_word_r};

  // A tick at the period value wraps to zero and raises the flag.
  always_comb begin
    count_low_nxt = count_low_r;
    count_high_nxt = count_high_r;
    ev_low = 1'b0;
    ev_high = 1'b0;
    if (concat) begin
      if (tick_low) begin
        if (pair_count == pair_period) begin
          {count_high_nxt, count_low_nxt} = 32'h0000_0000;
          ev_high = 1'b1;
        end else begin
          {count_high_nxt, count_low_nxt} = pair_count + 32'h0000_0001;
        end
      end
    end else begin
      if (tick_low) begin
        if (count_low_r == period_low_word_r) begin
          count_low_nxt = 16'h0000;
          ev_low = 1'b1;
        end else begin
          count_low_nxt = count_low_r + 16'h0001;
        end
      end
      if (tick_high) begin
        if (count_high_r == period_high_word_r) begin
          count_high_nxt = 16'h0000;
          ev_high = 1'b1;
        end else begin
          count_high_nxt = count_high_r + 16'h0001;
        end
      end
    end
    // A software write to a counter overrides the count step.
    if (wr_en && addr == TP_ADDR_COUNT_LOW) begin
      count_low_nxt = wdata;
    end
    if (wr_en && addr == TP_ADDR_COUNT_HIGH) begin
      count_high_nxt = wdata;
    end
  end

  // ----------------------------------------
  // Register writes and interrupt flags.
  // ----------------------------------------
  // All other writable state lives here.
  // Control writes are masked, so an
  // unimplemented bit is never stored.
  // Period and control may change while
  // running and apply from the next tick.
  // A period set below the count is met
  // only after the counter wraps.
  // Status bits stay set until cleared.
  // Software is trusted to configure fully before setting run.
  always_comb begin
    timer_low_control_nxt = timer_low_control_r;
    timer_high_control_nxt = timer_high_control_r;
    period_low_word_nxt = period_low_word_r;
    period_high_word_nxt = period_high_word_r;
    irq_enable_nxt = irq_enable_r;
    irq_prio_nxt = irq_prio_r;
    irq_stat_nxt = irq_stat_r;
    if (wr_en) begin
      unique case (addr)
        TP_ADDR_LOW_CTRL: timer_low_control_nxt = wdata & TP_LOW_CTRL_MASK;
        TP_ADDR_HIGH_CTRL: timer_high_control_nxt = wdata & TP_HIGH_CTRL_MASK;
        TP_ADDR_PERIOD_LOW: period_low_word_nxt = wdata;
        TP_ADDR_PERIOD_HIGH: period_high_word_nxt = wdata;
        TP_ADDR_IRQ_STATUS: irq_stat_nxt = irq_stat_r & ~wdata[1:0];
        TP_ADDR_IRQ_MASK: irq_enable_nxt = wdata[1:0];
        TP_ADDR_IRQ_PRIO: irq_prio_nxt = wdata[5:0];
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    if (ev_low) begin
      irq_stat_nxt[TP_IRQ_LOW] = 1'b1;
    end
    if (ev_high) begin
      irq_stat_nxt[TP_IRQ_HIGH] = 1'b1;
    end
  end

  // ----------------------------------------
  // Read port.
  // ----------------------------------------
  // Read data come from a register, so
  // no path runs from address to data.
  // Between reads the data return to
  // zero, so slaves can be ORed.
  // A read has no side effect; status
  // bits need an explicit clear.
  // Unmapped addresses read zero; data stand only in the cycle after the strobe.
  always_comb begin
    rdata_nxt = 16'h0000;
    if (rd_en) begin
      unique case (addr)
        TP_ADDR_LOW_CTRL: rdata_nxt = timer_low_control_r;
        TP_ADDR_HIGH_CTRL: rdata_nxt = timer_high_control_r;
        TP_ADDR_PERIOD_LOW: rdata_nxt = period_low_word_r;
        TP_ADDR_PERIOD_HIGH: rdata_nxt = period_high_word_r;
        TP_ADDR_COUNT_LOW: rdata_nxt = count_low_r;
        TP_ADDR_COUNT_HIGH: rdata_nxt = count_high_r;
        TP_ADDR_IRQ_STATUS: rdata_nxt = {14'h0000, irq_stat_r};
        TP_ADDR_IRQ_MASK: rdata_nxt = {14'h0000, irq_enable_r};
        TP_ADDR_IRQ_PRIO: rdata_nxt = {10'h000, irq_prio_r};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // One process registers all state.
  // Reset leaves timers stopped with
  // the largest period, so an unloaded
  // period counts the full 16 bits.
  // The reset branch uses constants only.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_low_control_r <= TP_CTRL_RST;
      timer_high_control_r <= TP_CTRL_RST;
      period_low_word_r <= TP_PERIOD_RST;
      period_high_word_r <= TP_PERIOD_RST;
      count_low_r <= 16'h0000;
      count_high_r <= 16'h0000;
      irq_stat_r <= 2'b00;
      irq_enable_r <= 2'b00;
      irq_prio_r <= 6'h00;
      rdata_r <= 16'h0000;
    end else begin
      timer_low_control_r <= timer_low_control_nxt;
      timer_high_control_r <= timer_high_control_nxt;
      period_low_word_r <= period_low_word_nxt;
      period_high_word_r <= period_high_word_nxt;
      count_low_r <= count_low_nxt;
      count_high_r <= count_high_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_enable_r <= irq_enable_nxt;
      irq_prio_r <= irq_prio_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

  // ----------------------------------------
  // Interrupt output.
  // ----------------------------------------
  // The interrupt is a level, high while
  // an unmasked status bit is set.
  // The priority follows the pending
  // source; in split mode the high
  // timer wins when both are pending.
  // The order is fixed and ignores the priority values.
  // In pair mode the low flag and enable are ignored.
  always_comb begin
    if (concat) begin
      irq = irq_stat_r[TP_IRQ_HIGH] & irq_enable_r[TP_IRQ_HIGH];
      irq_priority_out = irq_prio_r[5:3];
    end else begin
      irq = |(irq_stat_r & irq_enable_r);
      irq_priority_out = (irq_stat_r[TP_IRQ_HIGH] & irq_enable_r[TP_IRQ_HIGH]) ? irq_prio_r[5:3] : irq_prio_r[2:0];
    end
  end
endmodule
`default_nettype wire

/* File: tp_ext_src.sv */
// Model of the board sources that drive the two external timer clock pins.
`default_nettype none
module tp_ext_src (
  input wire logic mclk,
  input wire logic en_low,
  input wire logic en_high,
  output logic ext_clock_pin_low,
  output logic ext_clock_pin_high
);
  // ----------------------------------------
  // Pulse phase counters.
  // ----------------------------------------
  logic [1:0] ph_low_r; // Phase of the low pin source.
  logic [1:0] ph_high_r; // Phase of the high pin source.
  // One rising edge per four clocks while enabled; the phase restarts when idle.
  always_ff @(posedge mclk) begin
    ph_low_r <= en_low ? ph_low_r + 2'd1 : 2'd0;
    ph_high_r <= en_high ? ph_high_r + 2'd1 : 2'd0;
  end
  // Pins stand low outside a burst, so an enabled window of 4N clocks gives N edges.
  assign ext_clock_pin_low = en_low && ph_low_r[1];
  assign ext_clock_pin_high = en_high && ph_high_r[1];
endmodule
`default_nettype wire

/* File: tp_timer_pair_asserts.sv */
// Checker of register port and interrupt behaviour at the timer pair top.
`default_nettype none
module tp_timer_pair_asserts
  import tp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] rdata,
  input wire logic idle_mode,
  input wire logic ext_clock_pin_low,
  input wire logic ext_clock_pin_high,
  input wire logic gate_pin_low,
  input wire logic gate_pin_high,
  input wire logic irq,
  input wire logic [2:0] irq_priority_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Shadow of the low run bit.
  // ----------------------------------------
  logic run_r; // Last run bit written to the low control register.
  logic run_nxt; // Next value of the shadow.
  // The shadow lets a stopped counter be told from a running one.
  always_comb begin
    run_nxt = run_r;
    if (wr_en && addr == TP_ADDR_LOW_CTRL) begin
      run_nxt = wdata[TP_BIT_RUN];
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
    end
  end
  // ----------------------------------------
  // Assertions.
  // ----------------------------------------
  a_rdata_idle_zero: assert property (!$past(rd_en) |-> rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  a_low_ctl_bits: assert property (rd_en && addr == TP_ADDR_LOW_CTRL |=>
    (rdata & ~TP_LOW_CTRL_MASK) == 16'h0000) else $error("low control unimplemented bit set");
  a_high_ctl_bits: assert property (rd_en && addr == TP_ADDR_HIGH_CTRL |=>
    (rdata & ~TP_HIGH_CTRL_MASK) == 16'h0000) else $error("high control unimplemented bit set");
  a_unmapped_read_zero: assert property (rd_en && addr > TP_ADDR_IRQ_PRIO |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_ctl_write_back: assert property (wr_en && addr == TP_ADDR_LOW_CTRL ##1
    rd_en && addr == TP_ADDR_LOW_CTRL |=> rdata == ($past(wdata, 2) & TP_LOW_CTRL_MASK))
    else $error("low control read back wrong");
  a_period_write_back: assert property (wr_en && addr == TP_ADDR_PERIOD_LOW ##1
    rd_en && addr == TP_ADDR_PERIOD_LOW |=> rdata == $past(wdata, 2)) else $error("period read back wrong");
  a_irq_fall_write: assert property ($fell(irq) |-> $past(wr_en))
    else $error("interrupt dropped without a write");
  a_stopped_count_hold: assert property ((rd_en && addr == TP_ADDR_COUNT_LOW && !run_r && !$past(run_r, 4))
    ##1 (rd_en && addr == TP_ADDR_COUNT_LOW) |=> rdata == $past(rdata)) else $error("stopped counter moved");
  c_irq_rise: cover property ($rose(irq));
  c_unmapped_read: cover property (rd_en && addr > TP_ADDR_IRQ_PRIO);
  c_count_read: cover property (rd_en && addr == TP_ADDR_COUNT_HIGH);
endmodule
bind tp_timer_pair tp_timer_pair_asserts i_tp_timer_pair_asserts (.mclk(mclk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .idle_mode(idle_mode),
  .ext_clock_pin_low(ext_clock_pin_low), .ext_clock_pin_high(ext_clock_pin_high), .gate_pin_low(gate_pin_low),
  .gate_pin_high(gate_pin_high), .irq(irq), .irq_priority_out(irq_priority_out));
`default_nettype wire

/* File: testbench.sv */
// Self-checking testbench of the timer pair with its external pin source.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import tp_pkg::*;
  logic mclk, rst_n, wr_en, rd_en, idle_mode, gate_pin_low, gate_pin_high, en_low, en_high, irq, pend_r;
  logic ext_clock_pin_low, ext_clock_pin_high;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, v;
  logic [2:0] irq_priority_out;
  logic [15:0] exp_q[$]; // Expected read data, oldest first.
  logic [3:0] adr_q[$]; // Address of each pending read.
  int fails, total_checks, n;
  tp_timer_pair i_tp_timer_pair (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .idle_mode(idle_mode), .ext_clock_pin_low(ext_clock_pin_low),
    .ext_clock_pin_high(ext_clock_pin_high), .gate_pin_low(gate_pin_low), .gate_pin_high(gate_pin_high),
    .irq(irq), .irq_priority_out(irq_priority_out));
  tp_ext_src i_tp_ext_src (.mclk(mclk), .en_low(en_low), .en_high(en_high),
    .ext_clock_pin_low(ext_clock_pin_low), .ext_clock_pin_high(ext_clock_pin_high));
  // ----------------------------------------
  // Clock, checks and bus tasks.
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus cycle; every signal is assigned once, so calls may follow with no gap.
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    wr_en <= w;
    rd_en <= r;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    adr_q.push_back(a);
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask
  task automatic idle(input int k);
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    repeat (k) @(posedge mclk);
  endtask
  // Waits a bounded time for the interrupt, then checks it and its priority.
  task automatic irq_wait(input logic [2:0] p);
    for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge mclk);
    chk("irq", 16'h0001, {15'h0000, irq});
    chk("irq priority", {13'h0000, p}, {13'h0000, irq_priority_out});
  endtask
  task automatic irq_chk(input logic e);
    #1;
    chk("irq level", {15'h0000, e}, {15'h0000, irq});
  endtask
  // The answer stands only in the cycle after the strobe, so it is sampled mid-cycle.
  always @(posedge mclk) pend_r <= rd_en;
  always @(negedge mclk) begin
    if (pend_r === 1'b1 && exp_q.size() > 0) begin
      chk($sformatf("rdata at %h", adr_q.pop_front()), exp_q.pop_front(), rdata);
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // The tests need about 2,900 cycles; the limit leaves wide room.
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    complete_run();
  end
  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    {rst_n, wr_en, rd_en, idle_mode, gate_pin_low, gate_pin_high, en_low, en_high} = '0;
    addr = 4'h0;
    wdata = 16'h0000;
    void'($urandom(32'h317d8c97));
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rd(TP_ADDR_LOW_CTRL, TP_CTRL_RST);
    rd(TP_ADDR_HIGH_CTRL, TP_CTRL_RST);
    rd(TP_ADDR_PERIOD_HIGH, TP_PERIOD_RST);
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom()) & 16'h7FFF; // Run bits stay clear so the counts stay known.
      wr(TP_ADDR_LOW_CTRL, v);
      rd(TP_ADDR_LOW_CTRL, v & TP_LOW_CTRL_MASK);
      wr(TP_ADDR_HIGH_CTRL, v);
      rd(TP_ADDR_HIGH_CTRL, v & TP_HIGH_CTRL_MASK);
      v = 4'h9 + 4'($urandom() % 7);
      wr(v[3:0], 16'($urandom()));
      rd(v[3:0], 16'h0000);
    end
    wr(TP_ADDR_LOW_CTRL, 16'h0000);
    wr(TP_ADDR_HIGH_CTRL, 16'h0000);
    wr(TP_ADDR_PERIOD_LOW, 16'h0010);
    rd(TP_ADDR_PERIOD_LOW, 16'h0010);
    // Low counter on its pin, gate bit set but ignored: ten edges give ten counts.
    wr(TP_ADDR_LOW_CTRL, 16'h8042);
    en_low <= 1'b1;
    idle(39);
    en_low <= 1'b0;
    idle(8);
    rd(TP_ADDR_COUNT_LOW, 16'h000A);
    wr(TP_ADDR_LOW_CTRL, 16'h0000);
    idle(6);
    rd(TP_ADDR_COUNT_LOW, 16'h000A);
    rd(TP_ADDR_COUNT_LOW, 16'h000A);
    // High counter on its pin through each prescale code: 2*div edges add two.
    for (int k = 0; k < 4; k++) begin
      wr(TP_ADDR_HIGH_CTRL, 16'h8002 | (16'(k) << 4));
      en_high <= 1'b1;
      idle(8 * ((k == 3) ? 256 : (1 << (3 * k))) - 1);
      en_high <= 1'b0;
      idle(8);
      rd(TP_ADDR_COUNT_HIGH, 16'(2 * k + 2));
    end
    wr(TP_ADDR_HIGH_CTRL, 16'h0000);
    // Gated with the gate low, then halted in Idle: no counts either way.
    wr(TP_ADDR_LOW_CTRL, 16'h8040);
    idle(30);
    rd(TP_ADDR_COUNT_LOW, 16'h000A);
    // Four cycles with the gate high add four counts.
    gate_pin_low <= 1'b1;
    idle(3);
    gate_pin_low <= 1'b0;
    idle(4);
    rd(TP_ADDR_COUNT_LOW, 16'h000E);
    idle_mode <= 1'b1;
    wr(TP_ADDR_LOW_CTRL, 16'hA000);
    idle(30);
    rd(TP_ADDR_COUNT_LOW, 16'h000E);
    idle_mode <= 1'b0;
    // Low timer reaches its period and raises its flag.
    wr(TP_ADDR_IRQ_PRIO, 16'h0005);
    wr(TP_ADDR_IRQ_MASK, 16'h0001);
    wr(TP_ADDR_LOW_CTRL, 16'h8000);
    irq_wait(3'h5);
    wr(TP_ADDR_LOW_CTRL, 16'h0000);
    idle(4);
    rd(TP_ADDR_IRQ_STATUS, 16'h0001);
    wr(TP_ADDR_IRQ_MASK, 16'h0000);
    irq_chk(1'b0);
    wr(TP_ADDR_IRQ_MASK, 16'h0001);
    irq_chk(1'b1);
    wr(TP_ADDR_IRQ_STATUS, 16'h0001);
    irq_chk(1'b0);
    rd(TP_ADDR_IRQ_STATUS, 16'h0000);
    // Reset with both timers stopped clears the counts before the pair is joined.
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    wr(TP_ADDR_LOW_CTRL, 16'h0008);
    wr(TP_ADDR_PERIOD_LOW, 16'h0010);
    wr(TP_ADDR_PERIOD_HIGH, 16'h0000);
    wr(TP_ADDR_HIGH_CTRL, 16'h2030);
    wr(TP_ADDR_IRQ_MASK, 16'h0003);
    wr(TP_ADDR_IRQ_PRIO, 16'h0038);
    wr(TP_ADDR_LOW_CTRL, 16'h8008);
    irq_wait(3'h7);
    wr(TP_ADDR_LOW_CTRL, 16'h0008);
    idle(4);
    rd(TP_ADDR_IRQ_STATUS, 16'h0002);
    rd(TP_ADDR_COUNT_HIGH, 16'h0000);
    idle(4);
    complete_run();
  end
endmodule
`default_nettype wire
